// ===== design/adc_chain_device.sv
// Converter end: conversion timing, own word and chained shift path
//////////////////////////////////////////////////////////////////////
// How it works
// - Chain only in SPI or frame slave
// - First output to host, others chain onward
// - Last device chain input tied low
// - Device count bounded by period over bits
// - SPI pins shared by all devices
// - Host watches one ready output only
// - Host clocks whole chain within period
// - Chain word MSB follows own LSB
// - Frame slave pins shared, select low
// - Start restarts, keeps configuration
// - Power-down pin resets config, filter, interface
// - Start to first ready fixed per rate
// - Wake-up to first ready fixed per rate
// - Use power-down pin syncing frame master
// - All devices share one master clock
// - SPI output released while select high
// - Role select 0 slave, 1 master
//////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "adc_chain_defs.svh"

module adc_chain_device
    import adc_chain_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Link pins
    adc_chain_if.device io,
    // Straps
    input wire logic frameFormat,
    input wire logic frameRoleSelect,
    // Configuration write
    input wire logic cfgWrite,
    input wire logic [1:0] cfgRate,
    // Sample source
    input wire logic [31:0] sampleWord,
    output logic wordTaken,
    output logic [1:0] rateNow
);

    //////////////////////////////////////////////////////////////////
    // State and decoded events
    adc_dev_s stateReg;
    adc_dev_s stateNext;
    logic spiMode;
    logic masterMode;
    logic sclkRise;
    logic sclkFall;
    logic csFall;
    logic csHigh;
    logic startRise;
    logic wakeRise;
    logic poweredDown;
    logic chainSel;
    logic [13:0] periodLast;

    // Mode decode from straps
    assign spiMode = ~frameFormat;
    assign masterMode = frameFormat & frameRoleSelect;

    // Edges seen through the synchronisers
    assign sclkRise = stateReg.sclkS[1] & ~stateReg.sclkS[2];
    assign sclkFall = ~stateReg.sclkS[1] & stateReg.sclkS[2];
    assign csFall = ~stateReg.csS[1] & stateReg.csS[2];
    assign csHigh = stateReg.csS[1];
    assign startRise = stateReg.stS[1] & ~stateReg.stS[2];
    assign wakeRise = stateReg.rpS[1] & ~stateReg.rpS[2];
    assign poweredDown = ~stateReg.rpS[1];

    // Chain bits only pass in SPI or frame slave
    assign chainSel = masterMode ? 1'b0 : stateReg.chS[1];

    // Data period doubles with each rate step
    assign periodLast = 14'((`ADC_PERIOD_BASE << stateReg.rateCfg) - 14'h0001);

    //////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        stateNext = stateReg;
        stateNext.wordTaken = 1'b0;

        // Two-stage synchronisers, third stage for edges
        stateNext.sclkS = {stateReg.sclkS[1:0], io.serialClk};
        stateNext.csS = {stateReg.csS[1:0], io.chipSelectN};
        stateNext.frS = {stateReg.frS[1:0], io.frameLevel};
        stateNext.stS = {stateReg.stS[1:0], io.startPin};
        stateNext.rpS = {stateReg.rpS[1:0], io.resetPowerdownN};
        stateNext.chS = {stateReg.chS[0], io.chainIn};

        // Ready pulse and master frame pulse countdown
        if (stateReg.readyCnt != 4'h0) begin
            stateNext.readyCnt = stateReg.readyCnt - 4'h1;
        end
        if (stateReg.frameCnt != 4'h0) begin
            stateNext.frameCnt = stateReg.frameCnt - 4'h1;
        end

        // Configuration write, kept across start
        if (cfgWrite) begin
            stateNext.rateCfg = cfgRate;
        end

        // Start low halts, start or wake edge restarts timing
        if (!stateReg.stS[1]) begin
            stateNext.running = 1'b0;
        end else if (startRise || wakeRise) begin
            stateNext.running = 1'b1;
            stateNext.periodCnt = 14'h0000;
            stateNext.settleLeft = `ADC_SETTLE_PERIODS;
        end else if (stateReg.running) begin
            if (stateReg.periodCnt >= periodLast) begin
                stateNext.periodCnt = 14'h0000;
                if (stateReg.settleLeft != 2'h0) begin
                    // Filter settling, fixed count of periods
                    stateNext.settleLeft = stateReg.settleLeft - 2'h1;
                end else begin
                    stateNext.ownWord = sampleWord;
                    stateNext.wordTaken = 1'b1;
                    stateNext.readyCnt = `ADC_READY_LOW;
                    if (masterMode) begin
                        // Master frames its own word, chain unused
                        stateNext.frameCnt = `ADC_FRAME_HOLD;
                        stateNext.shiftReg = sampleWord;
                        stateNext.skipFall = 1'b1;
                    end
                end
            end else begin
                stateNext.periodCnt = stateReg.periodCnt + 14'h0001;
            end
        end

        // Shift path: load own word, then chain bits behind it
        if (spiMode && csFall) begin
            stateNext.shiftReg = stateReg.ownWord;
            stateNext.skipFall = 1'b0;
        end else if (!spiMode && !masterMode && sclkRise && stateReg.frS[1]) begin
            // Frame seen on a rising edge marks the word start
            stateNext.shiftReg = stateReg.ownWord;
            stateNext.skipFall = 1'b1;
        end else if (!(spiMode && csHigh)) begin
            if (sclkRise) begin
                stateNext.chainBit = chainSel;
            end
            if (sclkFall) begin
                if (stateReg.skipFall) begin
                    stateNext.skipFall = 1'b0;
                end else begin
                    // Own LSB is followed straight by chained MSB
                    stateNext.shiftReg = {stateReg.shiftReg[30:0], stateReg.chainBit};
                end
            end
        end

        // Power-down clears config, filter and interface state
        if (poweredDown) begin
            stateNext.rateCfg = `ADC_RATE_RESET;
            stateNext.running = 1'b0;
            stateNext.periodCnt = 14'h0000;
            stateNext.settleLeft = `ADC_SETTLE_PERIODS;
            stateNext.shiftReg = 32'h0000_0000;
            stateNext.chainBit = 1'b0;
            stateNext.skipFall = 1'b0;
            stateNext.readyCnt = 4'h0;
            stateNext.frameCnt = 4'h0;
            stateNext.ownWord = 32'h0000_0000;
        end
    end

    //////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stateReg <= '0;
            stateReg.csS <= `ADC_SYNC_HIGH;
            stateReg.stS <= `ADC_SYNC_LOW;
            stateReg.rpS <= `ADC_SYNC_LOW;
            stateReg.rateCfg <= `ADC_RATE_RESET;
            stateReg.settleLeft <= `ADC_SETTLE_PERIODS;
        end else begin
            stateReg <= stateNext;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Pin drive
    assign io.dout = stateReg.shiftReg[31];
    // SPI output released while select is high
    assign io.doutOe = ~poweredDown & (spiMode ? ~csHigh : 1'b1);
    assign io.devFrame = stateReg.frameCnt != 4'h0;
    assign io.devFrameOe = masterMode & ~poweredDown;
    assign io.conversionReadyN = stateReg.readyCnt == 4'h0;

    // User side status
    assign wordTaken = stateReg.wordTaken;
    assign rateNow = stateReg.rateCfg;

endmodule : adc_chain_device

// ===== design/adc_chain_host.sv
// Host end: serial clock divider, chain read-out and synchronisation pulses
`timescale 1ns/1ps
`include "adc_chain_defs.svh"

module adc_chain_host
    import adc_chain_pkg::*;
#(
    parameter int NUM_DEV = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Link pins
    adc_chain_if.host io,
    // Mode of the attached chain
    input wire logic spiMode,
    input wire logic frameRole,
    // Synchronisation requests
    input wire logic syncStart,
    input wire logic syncReset,
    // Received words
    output logic [31:0] wordOut,
    output logic [7:0] wordIndex,
    output logic wordValid,
    output logic busy
);

    //////////////////////////////////////////////////////////////////
    // State and decoded events
    adc_host_s stateReg;
    adc_host_s stateNext;
    logic halfDone;
    logic trigger;
    logic [7:0] lastWord;

    assign halfDone = stateReg.divCnt == `ADC_SCLK_HALF - 3'h1;
    // Frame master paces reads by its frame, else by one ready output
    assign trigger = frameRole ? (stateReg.frS[1] & ~stateReg.frS[2])
                               : (~stateReg.rdyS[1] & stateReg.rdyS[2]);
    // A frame master never chains, so one word per frame
    assign lastWord = frameRole ? 8'h00 : 8'(NUM_DEV - 1);

    //////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        stateNext = stateReg;
        stateNext.wordValid = 1'b0;
        stateNext.rdyS = {stateReg.rdyS[1:0], io.conversionReadyN};
        stateNext.frS = {stateReg.frS[1:0], io.frameLevel};
        stateNext.dS = {stateReg.dS[0], io.doutLevel};

        // Start and power-down pin pulses
        if (stateReg.pulseCnt != 4'h0) begin
            stateNext.pulseCnt = stateReg.pulseCnt - 4'h1;
            if (stateReg.pulseCnt == 4'h1) begin
                stateNext.startPin = 1'b1;
                stateNext.rpN = 1'b1;
            end
        end else if (syncReset) begin
            stateNext.rpN = 1'b0;
            stateNext.pulseCnt = `ADC_PIN_PULSE;
        end else if (syncStart) begin
            stateNext.startPin = 1'b0;
            stateNext.pulseCnt = `ADC_PIN_PULSE;
        end

        case (stateReg.state)
            HS_IDLE: begin
                stateNext.divCnt = 3'h0;
                stateNext.bitCnt = 5'h00;
                stateNext.devCnt = 8'h00;
                stateNext.sclk = 1'b0;
                stateNext.csN = spiMode;
                stateNext.frame = 1'b0;
                if (trigger) begin
                    stateNext.state = HS_LEAD;
                    stateNext.csN = 1'b0;
                    stateNext.frame = ~spiMode & ~frameRole;
                end
            end
            HS_LEAD: begin
                // One serial clock period before the first bit
                stateNext.divCnt = stateReg.divCnt + 3'h1;
                if (halfDone) begin
                    stateNext.divCnt = 3'h0;
                    stateNext.sclk = spiMode ? 1'b0 : ~stateReg.sclk;
                    stateNext.bitCnt = stateReg.bitCnt + 5'h01;
                    if (stateReg.bitCnt == 5'h01) begin
                        stateNext.state = HS_SHIFT;
                        stateNext.bitCnt = 5'h00;
                        stateNext.frame = 1'b0;
                    end
                end
            end
            HS_SHIFT: begin
                stateNext.divCnt = stateReg.divCnt + 3'h1;
                if (halfDone) begin
                    stateNext.divCnt = 3'h0;
                    stateNext.sclk = ~stateReg.sclk;
                    if (stateReg.sclk) begin
                        // Sample just before each falling edge
                        stateNext.shiftIn = {stateReg.shiftIn[30:0], stateReg.dS[1]};
                        stateNext.bitCnt = stateReg.bitCnt + 5'h01;
                        if (stateReg.bitCnt == 5'(`ADC_WORD_BITS - 1)) begin
                            stateNext.wordOut = {stateReg.shiftIn[30:0], stateReg.dS[1]};
                            stateNext.wordValid = 1'b1;
                            stateNext.wordIndex = stateReg.devCnt;
                            stateNext.devCnt = stateReg.devCnt + 8'h01;
                            if (stateReg.devCnt == lastWord) begin
                                // Whole chain read inside one period
                                stateNext.state = HS_IDLE;
                                stateNext.csN = spiMode;
                            end
                        end
                    end
                end
            end
            default: begin
                stateNext.state = HS_IDLE;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stateReg <= '0;
            stateReg.state <= HS_IDLE;
            stateReg.rdyS <= `ADC_SYNC_HIGH;
            stateReg.csN <= 1'b1;
            stateReg.startPin <= 1'b1;
            stateReg.rpN <= 1'b1;
        end else begin
            stateReg <= stateNext;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Pin drive, shared by every chained device
    assign io.serialClk = stateReg.sclk;
    assign io.chipSelectN = stateReg.csN;
    assign io.serialIn = 1'b0;
    assign io.hostFrame = stateReg.frame;
    assign io.hostFrameOe = ~spiMode & ~frameRole;
    assign io.startPin = stateReg.startPin;
    assign io.resetPowerdownN = stateReg.rpN;
    assign wordOut = stateReg.wordOut;
    assign wordIndex = stateReg.wordIndex;
    assign wordValid = stateReg.wordValid;
    assign busy = stateReg.state != HS_IDLE;

endmodule : adc_chain_host

// ===== include/adc_chain_defs.svh
// Timing, width and reset constants shared by both ends of the converter chain
`ifndef ADC_CHAIN_DEFS_SVH
`define ADC_CHAIN_DEFS_SVH
// Bits each device contributes to the chain
`define ADC_WORD_BITS 32
// Own clock and bench serial clock, in ns
`define ADC_REF_PERIOD_NS 100
`define ADC_SCLK_PERIOD_NS 800
// Host serial clock half period in reference cycles
`define ADC_SCLK_HALF 3'((`ADC_SCLK_PERIOD_NS) / (2 * `ADC_REF_PERIOD_NS))
// Data period for rate 0 in reference cycles, doubled per rate step
`define ADC_PERIOD_BASE 14'h0400
// Rate setting after reset or power-down
`define ADC_RATE_RESET 2'h0
// Whole data periods swallowed after start or wake-up
`define ADC_SETTLE_PERIODS 2'h2
// Cycles the ready output stays low
`define ADC_READY_LOW 4'h4
// Cycles a master-mode frame pulse stays high
`define ADC_FRAME_HOLD 4'h8
// Cycles the host holds start or power-down low
`define ADC_PIN_PULSE 4'h8
// Synchroniser reset values
`define ADC_SYNC_LOW 3'h0
`define ADC_SYNC_HIGH 3'h7
`endif

// ===== include/adc_chain_if.sv
// Pin bundle between one converter and the host side of the chain
`timescale 1ns/1ps
interface adc_chain_if;
    logic serialClk;
    logic chipSelectN;
    logic serialIn;
    logic hostFrame;
    logic hostFrameOe;
    logic devFrame;
    logic devFrameOe;
    logic frameLevel;
    logic dout;
    logic doutOe;
    logic doutLevel;
    logic chainIn;
    logic conversionReadyN;
    logic startPin;
    logic resetPowerdownN;

    // Shared frame wire, the device wins when it drives
    assign frameLevel = devFrameOe ? devFrame : (hostFrameOe & hostFrame);
    // Released data line reads low
    assign doutLevel = doutOe & dout;

    modport device (
        input serialClk, chipSelectN, serialIn, frameLevel, chainIn, startPin, resetPowerdownN,
        output dout, doutOe, devFrame, devFrameOe, conversionReadyN
    );
    modport host (
        input doutLevel, frameLevel, conversionReadyN,
        output serialClk, chipSelectN, serialIn, hostFrame, hostFrameOe, startPin, resetPowerdownN
    );
endinterface : adc_chain_if

// ===== include/adc_chain_pkg.sv
// Types shared by both ends of the converter chain
package adc_chain_pkg;
    typedef enum {HS_IDLE, HS_LEAD, HS_SHIFT} adc_host_state_e;

    typedef struct packed {
        logic [2:0] sclkS;
        logic [2:0] csS;
        logic [2:0] frS;
        logic [2:0] stS;
        logic [2:0] rpS;
        logic [1:0] chS;
        logic [31:0] shiftReg;
        logic chainBit;
        logic skipFall;
        logic [1:0] rateCfg;
        logic [13:0] periodCnt;
        logic [1:0] settleLeft;
        logic running;
        logic [3:0] readyCnt;
        logic [3:0] frameCnt;
        logic [31:0] ownWord;
        logic wordTaken;
    } adc_dev_s;

    typedef struct packed {
        adc_host_state_e state;
        logic [2:0] divCnt;
        logic sclk;
        logic [4:0] bitCnt;
        logic [7:0] devCnt;
        logic [2:0] rdyS;
        logic [2:0] frS;
        logic [1:0] dS;
        logic [31:0] shiftIn;
        logic [31:0] wordOut;
        logic wordValid;
        logic [7:0] wordIndex;
        logic csN;
        logic frame;
        logic startPin;
        logic rpN;
        logic [3:0] pulseCnt;
    } adc_host_s;
endpackage : adc_chain_pkg

// ===== tb/adc_chain_properties.sv
// Concurrent checks on the link between the host and the first converter
`timescale 1ns/1ps
module adc_chain_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Link signals
    input wire logic serialClk,
    input wire logic chipSelectN,
    input wire logic serialIn,
    input wire logic devFrame,
    input wire logic devFrameOe,
    input wire logic dout,
    input wire logic doutOe,
    input wire logic conversionReadyN,
    input wire logic resetPowerdownN,
    // Straps
    input wire logic frameFormat,
    input wire logic frameRoleSelect
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    //////////////////////////////////////////////////////////////////////
    // Ready pulse is exactly four cycles
    property p_readyPulse;
        disable iff (reset || !resetPowerdownN)
        $fell(conversionReadyN) |-> !conversionReadyN [*4] ##1 conversionReadyN;
    endproperty
    a_readyPulse: assert property (p_readyPulse) else $error("ready pulse width wrong");
    // Master frame pulse is exactly eight cycles
    property p_frameHold;
        disable iff (reset || !resetPowerdownN)
        $rose(devFrame) |-> devFrame [*8] ##1 !devFrame;
    endproperty
    a_frameHold: assert property (p_frameHold) else $error("frame pulse width wrong");
    // A slave never drives the frame wire
    property p_slaveNoFrame;
        !frameRoleSelect |-> !devFrameOe;
    endproperty
    a_slaveNoFrame: assert property (p_slaveNoFrame) else $error("slave drives frame");
    // Deselected SPI output is released
    property p_csRelease;
        (!frameFormat && chipSelectN) [*4] |-> !doutOe;
    endproperty
    a_csRelease: assert property (p_csRelease) else $error("output driven while deselected");
    // Host data input is unused and low
    property p_dinLow;
        !serialIn;
    endproperty
    a_dinLow: assert property (p_dinLow) else $error("serial input not low");
    // Serial clock high phase is four cycles
    property p_sclkHalf;
        $rose(serialClk) |-> serialClk [*4] ##1 !serialClk;
    endproperty
    a_sclkHalf: assert property (p_sclkHalf) else $error("serial clock half period wrong");
    // SPI select leads the first clock edge
    property p_leadLow;
        !frameFormat && $fell(chipSelectN) |-> !serialClk [*8];
    endproperty
    a_leadLow: assert property (p_leadLow) else $error("clock too soon after select");
    // Output holds for two cycles after a falling clock
    property p_doutSettle;
        disable iff (reset || !resetPowerdownN)
        $fell(serialClk) && !chipSelectN |=> $stable(dout) [*2];
    endproperty
    a_doutSettle: assert property (p_doutSettle) else $error("output moved too early");
    // Idle SPI host answers a ready pulse
    property p_readyAnswer;
        !frameFormat && chipSelectN && $fell(conversionReadyN) |-> ##[2:8] !chipSelectN;
    endproperty
    a_readyAnswer: assert property (p_readyAnswer) else $error("host ignored ready");
    // Power-down releases data and frame outputs and holds ready high
    property p_powerDown;
        !resetPowerdownN [*5] |-> conversionReadyN && !doutOe && !devFrameOe;
    endproperty
    a_powerDown: assert property (p_powerDown) else $error("outputs kept in power-down");
    // Frame mode keeps select low once low
    property p_frameSelect;
        frameFormat && !chipSelectN |=> !chipSelectN;
    endproperty
    a_frameSelect: assert property (p_frameSelect) else $error("select rose in frame mode");
endmodule : adc_chain_properties

// ===== tb/adc_daisy_chain_sync_bench.sv
// Self-checking bench: host end reading a chain of two converters
`timescale 1ns/1ps
`include "adc_chain_defs.svh"
module adc_daisy_chain_sync_bench;
    import adc_chain_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic frameFormat = 1'b0;
    logic frameRole = 1'b0;
    logic cfgWrite = 1'b0;
    logic [1:0] cfgRate = 2'h0;
    logic syncStart = 1'b0;
    logic syncReset = 1'b0;
    logic noiseBit = 1'b0;
    logic chk = 1'b0;
    logic [31:0] sampleWord [2];
    logic [31:0] latest [2];
    logic [31:0] wordOut;
    logic [7:0] wordIndex;
    logic [7:0] expIdx = 8'h00;
    logic wordValid;
    logic hostBusy;
    logic [1:0] taken;
    logic [1:0] rateNow;
    int errors = 0;
    int comparisons = 0;
    int wordsSeen = 0;
    int seed = 32'hce3e;
    int lat;
    int lat0;
    adc_chain_if io0 ();
    adc_chain_if io1 ();

    //////////////////////////////////////////////////////////////////////
    // Shared host pins reach the far converter too
    assign io1.serialClk = io0.serialClk;
    assign io1.chipSelectN = io0.chipSelectN;
    assign io1.serialIn = io0.serialIn;
    assign io1.hostFrame = io0.hostFrame;
    assign io1.hostFrameOe = io0.hostFrameOe;
    assign io1.startPin = io0.startPin;
    assign io1.resetPowerdownN = io0.resetPowerdownN;
    // Chain wiring; master mode sees noise that must be ignored
    assign io0.chainIn = frameRole ? noiseBit : io1.doutLevel;
    assign io1.chainIn = 1'b0;

    // Both ends and the checker
    adc_chain_device i_adc_chain_device_0 (.ref_clk(ref_clk), .reset(reset), .io(io0.device),
        .frameFormat(frameFormat), .frameRoleSelect(frameRole), .cfgWrite(cfgWrite), .cfgRate(cfgRate),
        .sampleWord(sampleWord[0]), .wordTaken(taken[0]), .rateNow(rateNow));
    adc_chain_device i_adc_chain_device_1 (.ref_clk(ref_clk), .reset(reset), .io(io1.device),
        .frameFormat(frameFormat), .frameRoleSelect(1'b0), .cfgWrite(cfgWrite), .cfgRate(cfgRate),
        .sampleWord(sampleWord[1]), .wordTaken(taken[1]), .rateNow());
    adc_chain_host #(.NUM_DEV(2)) i_adc_chain_host (.ref_clk(ref_clk), .reset(reset), .io(io0.host),
        .spiMode(!frameFormat), .frameRole(frameRole), .syncStart(syncStart), .syncReset(syncReset),
        .wordOut(wordOut), .wordIndex(wordIndex), .wordValid(wordValid), .busy(hostBusy));
    adc_chain_properties i_adc_chain_properties (.ref_clk(ref_clk), .reset(reset),
        .serialClk(io0.serialClk), .chipSelectN(io0.chipSelectN), .serialIn(io0.serialIn),
        .devFrame(io0.devFrame), .devFrameOe(io0.devFrameOe), .dout(io0.dout), .doutOe(io0.doutOe),
        .conversionReadyN(io0.conversionReadyN), .resetPowerdownN(io0.resetPowerdownN),
        .frameFormat(frameFormat), .frameRoleSelect(frameRole));

    // Reference clock
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    //////////////////////////////////////////////////////////////////////
    // Compare, report, finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t %s: saw %h, expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    task automatic timed_out(input string what);
        errors++;
        $display("ERROR %0t timeout waiting for %s", $time, what);
        end_of_test();
    endtask : timed_out

    // Expected values
    function automatic logic [31:0] expected_word(input logic [7:0] idx);
        return latest[idx[0]];
    endfunction : expected_word

    function automatic int settle_cycles(input logic [1:0] r);
        return 3 * (int'(`ADC_PERIOD_BASE) << r);
    endfunction : settle_cycles

    function automatic logic pin_now(input logic useReset);
        return useReset ? io0.resetPowerdownN : io0.startPin;
    endfunction : pin_now

    // Word monitor, sample bookkeeping and chain noise
    always @(negedge ref_clk) begin
        noiseBit <= 1'($random(seed));
        if (wordValid === 1'b1) begin
            wordsSeen++;
            if (chk) begin
                check({24'h0, wordIndex}, {24'h0, expIdx}, "word index");
                check(wordOut, expected_word(wordIndex), "chained word");
            end
            expIdx = (frameRole || expIdx == 8'h01) ? 8'h00 : expIdx + 8'h01;
        end
        for (int d = 0; d < 2; d++) begin
            if (taken[d] === 1'b1) begin
                latest[d] = sampleWord[d];
                sampleWord[d] = $random(seed);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Reset into a given interface mode
    task automatic do_reset(input logic fmt, input logic role);
        reset = 1'b1;
        frameFormat = fmt;
        frameRole = role;
        expIdx = 8'h00;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
    endtask : do_reset

    task automatic wait_words(input int n);
        int target;
        target = wordsSeen + n;
        for (int i = 0; i < 20000 && wordsSeen < target; i++) @(negedge ref_clk);
        if (wordsSeen < target) timed_out("words");
    endtask : wait_words

    // Pulse a sync request, count cycles from pin release to first ready
    task automatic sync_latency(input logic useReset, output int n);
        syncReset = useReset;
        syncStart = !useReset;
        @(negedge ref_clk);
        syncReset = 1'b0;
        syncStart = 1'b0;
        for (n = 0; n < 20 && pin_now(useReset) !== 1'b0; n++) @(negedge ref_clk);
        if (n == 20) timed_out("pin low");
        for (n = 0; n < 20 && pin_now(useReset) !== 1'b1; n++) @(negedge ref_clk);
        if (n == 20) timed_out("pin high");
        for (n = 0; n < 40000 && io0.conversionReadyN !== 1'b0; n++) @(negedge ref_clk);
        if (n == 40000) timed_out("ready");
    endtask : sync_latency

    // Main sequence
    initial begin
        for (int d = 0; d < 2; d++) begin
            sampleWord[d] = $random(seed);
            latest[d] = 32'h0;
        end
        chk = 1'b1;
        do_reset(1'b0, 1'b0);
        repeat (6) @(negedge ref_clk);
        check({31'h0, io0.doutOe}, 32'h0, "idle output enable");
        check({31'h0, io0.serialClk}, 32'h0, "idle serial clock");
        check({31'h0, hostBusy}, 32'h0, "host idle before ready");
        wait_words(6);
        // Every rate: start keeps the setting and has a fixed latency
        chk = 1'b0;
        for (int r = 0; r < 4; r++) begin
            cfgRate = 2'(r);
            cfgWrite = 1'b1;
            @(negedge ref_clk);
            cfgWrite = 1'b0;
            sync_latency(1'b0, lat);
            check({30'h0, rateNow}, 32'(r), "rate kept by start");
            check(32'(lat >= settle_cycles(2'(r)) && lat <= settle_cycles(2'(r)) + 8), 32'h1, "start latency");
            if (r == 0) lat0 = lat;
        end
        // Power-down restores the rate and wakes with fixed latency
        sync_latency(1'b1, lat);
        check({30'h0, rateNow}, 32'h0, "rate after power-down");
        check(32'(lat >= settle_cycles(2'h0) && lat <= settle_cycles(2'h0) + 8), 32'h1, "wake latency");
        cfgRate = 2'h0;
        sync_latency(1'b0, lat);
        check(32'(lat), 32'(lat0), "repeat start latency");
        // Frame slave chain, then master reading its own word only
        chk = 1'b1;
        do_reset(1'b1, 1'b0);
        wait_words(6);
        do_reset(1'b1, 1'b1);
        wait_words(3);
        check({31'h0, io0.devFrameOe}, 32'h1, "master drives frame");
        end_of_test();
    end
endmodule : adc_daisy_chain_sync_bench
